// ===== hdl/ipb_pkg.sv
/*
  Constants for the interrupt priority bank: register map, field
  placement per source, reset values and vector coding.
  Assumes a 32-bit APB with word-aligned registers.
*/
package ipb_pkg;

  localparam int NUM_SRC  = 24;
  localparam int NUM_TRAP = 8;
  localparam int NUM_PREG = 13;
  localparam int NUM_EVT  = 3;
  localparam int PW       = 3;
  localparam int AW       = 12;
  localparam int LVL_W    = 4;
  localparam int VEC_W    = 7;
  localparam int IDX_W    = 5;

  localparam logic [PW-1:0]    PRIO_RST       = 3'h4;
  localparam logic [PW-1:0]    PRIO_OFF       = 3'h0;
  localparam logic [LVL_W-1:0] TRAP_BASE      = 4'h8;
  localparam logic [VEC_W-1:0] USER_CODE_BASE = 7'h08;
  localparam logic [LVL_W-1:0] LVL_RST        = 4'h0;
  localparam logic [VEC_W-1:0] VEC_RST        = 7'h00;

  // Priority registers sit at OFS_PRIO0 + 4 * index
  localparam logic [AW-1:0] OFS_PRIO0    = 12'h000;
  localparam logic [AW-1:0] OFS_STATUS   = 12'h034;
  localparam logic [AW-1:0] OFS_ENABLE   = 12'h038;
  localparam logic [AW-1:0] OFS_EVT_STS  = 12'h03C;
  localparam logic [AW-1:0] OFS_EVT_MASK = 12'h040;

  localparam int STS_LVL_LSB = 8;
  localparam int STS_VEC_LSB = 0;

  localparam int EVT_USER  = 0;
  localparam int EVT_TRAP  = 1;
  localparam int EVT_BLOCK = 2;

  // Source order: adc done, serial tx, pin change, comparator 1,
  // two-wire master/slave, ext irq 1/2, pwm special event, serial
  // error, pwm 2/1/4/3, comparator 2/4/3, adc pair 1/0/5/4/3/2/6
  localparam int unsigned SRC_REG [NUM_SRC] = '{
    0, 0, 1, 1, 1, 1, 2, 3, 4, 5, 6, 6,
    7, 7, 8, 9, 9, 10, 10, 11, 11, 11, 11, 12};
  localparam int unsigned SRC_POS [NUM_SRC] = '{
    4, 0, 12, 8, 4, 0, 0, 4, 4, 4, 12, 8,
    4, 0, 12, 4, 0, 12, 8, 12, 8, 4, 0, 0};

endpackage : ipb_pkg

// ===== hdl/ipb_arbiter.sv
/*
  Combinational winner selection among traps and user sources.
  Assumes request, enable and level inputs share the bank's clock.
*/
`timescale 1ns/1ps
module ipb_arbiter
  import ipb_pkg::*;
(
  input  wire logic [NUM_SRC-1:0]  req,
  input  wire logic [NUM_SRC-1:0]  en,
  input  wire logic [PW-1:0]       prio [NUM_SRC],
  input  wire logic [NUM_TRAP-1:0] trap,
  input  wire logic [LVL_W-1:0]    cpu_level,
  output logic                     win_valid,
  output logic [LVL_W-1:0]         win_level,
  output logic [VEC_W-1:0]         win_code,
  output logic [IDX_W-1:0]         win_idx,
  output logic                     win_trap
);

  logic [NUM_SRC-1:0] elig;

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_elig
    assign elig[s] = req[s] & en[s] & (prio[s] != PRIO_OFF)
                   & ({1'b0, prio[s]} > cpu_level);
  end

  // level from code
  // Descending scan with >= lets the lower vector win a tie
  always_comb begin
    win_valid = 1'b0;
    win_level = LVL_RST;
    win_code  = VEC_RST;
    win_idx   = '0;
    win_trap  = 1'b0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (elig[s] && (!win_valid || {1'b0, prio[s]} >= win_level)) begin
        win_valid = 1'b1;
        win_level = {1'b0, prio[s]};
        win_code  = USER_CODE_BASE + VEC_W'(s);
        win_idx   = IDX_W'(s);
      end
    end
    // traps never masked
    // Traps outrank every user level and ignore the CPU level
    for (int t = 0; t < NUM_TRAP; t++) begin
      if (trap[t]) begin
        win_valid = 1'b1;
        win_level = TRAP_BASE + LVL_W'(t);
        win_code  = VEC_W'(t);
        win_idx   = '0;
        win_trap  = 1'b1;
      end
    end
  end

endmodule : ipb_arbiter

// ===== hdl/ipb_evt_status.sv
/*
  Sticky event status with mask and one level interrupt.
  Assumes write strobes are single-cycle pulses on pclk.
*/
`timescale 1ns/1ps
module ipb_evt_status #(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [N-1:0] clr_data,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] mask_data,
  output logic      [N-1:0] sts_q,
  output logic      [N-1:0] mask_q,
  output logic              irq
);

  logic [N-1:0] sts_d;

  // A set in the clearing cycle survives
  assign sts_d = (sts_q & ~(clr_we ? clr_data : '0)) | set;
  assign irq   = |(sts_q & mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q  <= '0;
      mask_q <= '0;
    end else begin
      sts_q <= sts_d;
      if (mask_we) begin
        mask_q <= mask_data;
      end
    end
  end

endmodule : ipb_evt_status

// ===== hdl/ipb_bank.sv
/*
  Interrupt priority bank: per-source priority fields, enables,
  arbitration, presentation to the CPU core and a status register
  with the accepted level and vector. APB slave, zero wait states.
  Assumes requests, CPU level and acknowledge are on pclk.
*/
`timescale 1ns/1ps
module ipb_bank
  import ipb_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [AW-1:0]       paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_SRC-1:0]  src_req,
  input  wire logic [NUM_TRAP-1:0] trap_req,
  input  wire logic [LVL_W-1:0]    cpu_level,
  input  wire logic                cpu_ack,
  output logic                     irq_pending,
  output logic      [LVL_W-1:0]    irq_level,
  output logic      [VEC_W-1:0]    irq_vector,
  output logic                     evt_irq
);

  logic [PW-1:0]      prio_q [NUM_SRC];
  logic [15:0]        preg_word [NUM_PREG];
  logic [NUM_SRC-1:0] en_q;
  logic [LVL_W-1:0]   sts_lvl_q;
  logic [VEC_W-1:0]   sts_vec_q;
  logic               pres_valid_q;
  logic [LVL_W-1:0]   pres_lvl_q;
  logic [VEC_W-1:0]   pres_code_q;
  logic [IDX_W-1:0]   pres_idx_q;
  logic               pres_trap_q;
  logic [31:0]        prdata_q;
  logic [31:0]        prdata_d;
  logic               arb_valid;
  logic [LVL_W-1:0]   arb_lvl;
  logic [VEC_W-1:0]   arb_code;
  logic [IDX_W-1:0]   arb_idx;
  logic               arb_trap;
  logic [NUM_SRC-1:0] blocked;
  logic [NUM_EVT-1:0] evt_set;
  logic [NUM_EVT-1:0] evt_sts;
  logic [NUM_EVT-1:0] evt_mask;

  // APB decode
  wire [AW-3:0] widx     = paddr[AW-1:2];
  wire          aligned  = (paddr[1:0] == 2'h0);
  wire          setup    = psel & ~penable;
  wire          access   = psel & penable;
  wire          wr       = access & pwrite;
  wire          rd_setup = setup & ~pwrite;
  wire          hit_prio = aligned && (paddr >= OFS_PRIO0)
                        && (widx < (AW-2)'(NUM_PREG));
  wire          hit_sts  = (paddr == OFS_STATUS);
  wire          hit_en   = (paddr == OFS_ENABLE);
  wire          hit_evs  = (paddr == OFS_EVT_STS);
  wire          hit_evm  = (paddr == OFS_EVT_MASK);
  wire          hit      = hit_prio | hit_sts | hit_en | hit_evs | hit_evm;
  wire [AW-3:0] pidx     = widx - OFS_PRIO0[AW-1:2];

  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = prdata_q;

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_field
    localparam int unsigned R = SRC_REG[s];
    localparam int unsigned P = SRC_POS[s];
    wire fld_we = wr & hit_prio & (pidx == (AW-2)'(R)) & pstrb[P/8];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prio_q[s] <= PRIO_RST;
      end else if (fld_we) begin
        prio_q[s] <= pwdata[P +: PW];
      end
    end
    assign blocked[s] = src_req[s] & en_q[s] & (prio_q[s] == PRIO_OFF);
  end

  always_comb begin
    for (int r = 0; r < NUM_PREG; r++) begin
      preg_word[r] = 16'h0000;
    end
    for (int s = 0; s < NUM_SRC; s++) begin
      preg_word[SRC_REG[s]][SRC_POS[s] +: PW] = prio_q[s];
    end
  end

  wire [15:0] sts_word = {4'h0, sts_lvl_q, 1'b0, sts_vec_q};
  wire [15:0] prio_rd  = hit_prio ? preg_word[pidx[3:0]] : 16'h0000;

  assign prdata_d = hit_prio ? {16'h0000, prio_rd}
                  : hit_sts  ? {16'h0000, sts_word}
                  : hit_en   ? {{(32-NUM_SRC){1'b0}}, en_q}
                  : hit_evs  ? {{(32-NUM_EVT){1'b0}}, evt_sts}
                  : hit_evm  ? {{(32-NUM_EVT){1'b0}}, evt_mask}
                  : 32'h0000_0000;

  // Read data captured at setup so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else if (wr && hit_en) begin
      for (int b = 0; b < NUM_SRC / 8; b++) begin
        if (pstrb[b]) begin
          en_q[b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
    end
  end

  ipb_arbiter u_arb (
    .req       (src_req),
    .en        (en_q),
    .prio      (prio_q),
    .trap      (trap_req),
    .cpu_level (cpu_level),
    .win_valid (arb_valid),
    .win_level (arb_lvl),
    .win_code  (arb_code),
    .win_idx   (arb_idx),
    .win_trap  (arb_trap)
  );

  // Registered presentation breaks the long compare path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_valid_q <= 1'b0;
      pres_lvl_q   <= LVL_RST;
      pres_code_q  <= VEC_RST;
      pres_idx_q   <= '0;
      pres_trap_q  <= 1'b0;
    end else begin
      pres_valid_q <= arb_valid;
      pres_lvl_q   <= arb_lvl;
      pres_code_q  <= arb_code;
      pres_idx_q   <= arb_idx;
      pres_trap_q  <= arb_trap;
    end
  end

  assign irq_pending = pres_valid_q;
  assign irq_level   = pres_lvl_q;
  assign irq_vector  = pres_code_q;

  wire accept = cpu_ack & pres_valid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_lvl_q <= LVL_RST;
      sts_vec_q <= VEC_RST;
    end else if (accept) begin
      sts_lvl_q <= pres_lvl_q;
      sts_vec_q <= pres_code_q;
    end
  end

  assign evt_set[EVT_USER]  = accept & ~pres_trap_q;
  assign evt_set[EVT_TRAP]  = accept & pres_trap_q;
  assign evt_set[EVT_BLOCK] = |blocked;

  ipb_evt_status #(
    .N (NUM_EVT)
  ) u_evt (
    .pclk      (pclk),
    .presetn   (presetn),
    .set       (evt_set),
    .clr_we    (wr & hit_evs & pstrb[0]),
    .clr_data  (pwdata[NUM_EVT-1:0]),
    .mask_we   (wr & hit_evm & pstrb[0]),
    .mask_data (pwdata[NUM_EVT-1:0]),
    .sts_q     (evt_sts),
    .mask_q    (evt_mask),
    .irq       (evt_irq)
  );

  // Assertions

  a_off_never_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    arb_valid && !arb_trap
    |=> pres_idx_q == $past(arb_idx) && $past(prio_q[arb_idx]) != PRIO_OFF)
    else $error("disabled source presented");

  a_user_level_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    arb_valid && !arb_trap |-> arb_lvl != 4'h0 && arb_lvl <= 4'h7)
    else $error("user level outside one to seven");

  a_blocked_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    |blocked |=> evt_sts[EVT_BLOCK])
    else $error("blocked request not flagged");

  a_level_is_code: assert property (
    @(posedge pclk) disable iff (!presetn)
    arb_valid && !arb_trap && !$changed(prio_q[arb_idx])
    |=> !pres_trap_q && pres_lvl_q == {1'b0, $past(prio_q[arb_idx])})
    else $error("user level differs from field code");

  a_upper_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && (hit_prio || hit_sts)
    |=> prdata[31:16] == 16'h0000 && prdata[15] == 1'b0)
    else $error("unimplemented bits read nonzero");

  a_adc_field_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_PRIO0 && pstrb[0]
    |=> prio_q[0] == $past(pwdata[6:4]) && prio_q[1] == $past(pwdata[2:0]))
    else $error("adc or transmit field misplaced");

  a_change_i2c_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(1) && pstrb[1] && pstrb[0]
    |=> prio_q[2] == $past(pwdata[14:12]) && prio_q[3] == $past(pwdata[10:8])
    && prio_q[4] == $past(pwdata[6:4]) && prio_q[5] == $past(pwdata[2:0]))
    else $error("change or two-wire field misplaced");

  a_ext_one_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(2) && pstrb[0]
    |=> prio_q[6] == $past(pwdata[2:0]))
    else $error("external irq one field misplaced");

  a_ext_two_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(3) && pstrb[0]
    |=> prio_q[7] == $past(pwdata[6:4]))
    else $error("external irq two field misplaced");

  a_pwm_event_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(4) && pstrb[0]
    |=> prio_q[8] == $past(pwdata[6:4]))
    else $error("pwm special event field misplaced");

  a_serial_err_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(5) && pstrb[0]
    |=> prio_q[9] == $past(pwdata[6:4]))
    else $error("serial error field misplaced");

  a_pwm_upper_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(6) && pstrb[1]
    |=> prio_q[10] == $past(pwdata[14:12])
    && prio_q[11] == $past(pwdata[10:8]))
    else $error("pwm one or two field misplaced");

  a_pwm_lower_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(7) && pstrb[0]
    |=> prio_q[12] == $past(pwdata[6:4])
    && prio_q[13] == $past(pwdata[2:0]))
    else $error("pwm three or four field misplaced");

  a_comparator_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(9) && pstrb[0]
    |=> prio_q[15] == $past(pwdata[6:4])
    && prio_q[16] == $past(pwdata[2:0]))
    else $error("comparator three or four field misplaced");

  a_adc_pair_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_prio && pidx == (AW-2)'(11) && pstrb[1] && pstrb[0]
    |=> prio_q[19] == $past(pwdata[14:12])
    && prio_q[20] == $past(pwdata[10:8])
    && prio_q[21] == $past(pwdata[6:4]) && prio_q[22] == $past(pwdata[2:0]))
    else $error("adc pair two to five field misplaced");

  a_trap_unmasked: assert property (
    @(posedge pclk) disable iff (!presetn)
    |trap_req |=> pres_valid_q && pres_trap_q && pres_lvl_q >= TRAP_BASE)
    else $error("trap not presented");

  a_enable_gates: assert property (
    @(posedge pclk) disable iff (!presetn)
    arb_valid && !arb_trap |-> en_q[arb_idx] && src_req[arb_idx])
    else $error("disabled request selected");

  a_above_cpu: assert property (
    @(posedge pclk) disable iff (!presetn)
    arb_valid && !arb_trap |-> arb_lvl > cpu_level)
    else $error("winner not above cpu level");

  a_status_loads: assert property (
    @(posedge pclk) disable iff (!presetn)
    accept |=> sts_lvl_q == $past(pres_lvl_q) && sts_vec_q == $past(pres_code_q))
    else $error("status missed acceptance");

  a_status_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    !accept |=> $stable(sts_lvl_q) && $stable(sts_vec_q))
    else $error("status moved without acceptance");

  a_status_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && hit_sts |=> prdata[11:8] == $past(sts_lvl_q)
    && prdata[6:0] == $past(sts_vec_q))
    else $error("status read mismatch");

endmodule : ipb_bank

// ===== test/ipb_cpu_model.sv
/*
  CPU-side partner: accepts a presented request once per arming.
  Assumes the bank presents requests on registered pclk outputs.
*/
`timescale 1ns/1ps
module ipb_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       arm,
  input  wire logic [3:0] dly,
  input  wire logic       irq_pending,
  output logic            cpu_ack
);
  logic [3:0] cnt_q;
  logic       done_q;

  // Slow acceptance keeps the request presented for a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 4'h0;
      done_q  <= 1'b0;
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      if (!arm) begin
        cnt_q  <= 4'h0;
        done_q <= 1'b0;
      end else if (irq_pending && !done_q) begin
        if (cnt_q == dly) begin
          cpu_ack <= 1'b1;
          done_q  <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : ipb_cpu_model

// ===== test/tb.sv
/*
  Self-checking bench for the priority bank: APB tasks, request stimulus.
  Assumes a zero-wait APB slave and the CPU partner model.
*/
`timescale 1ns/1ps
module tb
  import ipb_pkg::*;
;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]       paddr;
  logic [31:0]         pwdata, prdata;
  logic [3:0]          pstrb, cpu_level, irq_level, dly;
  logic [NUM_SRC-1:0]  src_req;
  logic [NUM_TRAP-1:0] trap_req;
  logic                cpu_ack, irq_pending, evt_irq, arm;
  logic [VEC_W-1:0]    irq_vector;
  logic [31:0]         shadow [NUM_PREG];
  int                  miscompares, checks;

  always #5 pclk = ~pclk;

  ipb_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .trap_req(trap_req),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .irq_pending(irq_pending),
    .irq_level(irq_level), .irq_vector(irq_vector), .evt_irq(evt_irq));

  ipb_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .arm(arm), .dly(dly),
    .irq_pending(irq_pending), .cpu_ack(cpu_ack));

  task automatic close_out();
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      miscompares++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask : rd_chk

  function automatic logic [AW-1:0] pa(input int i);
    return OFS_PRIO0 + AW'(4 * i);
  endfunction : pa

  function automatic logic [31:0] fmask(input int i, input logic [2:0] v);
    logic [31:0] m;
    m = 32'h0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (SRC_REG[s] == i) m |= 32'(v) << SRC_POS[s];
    end
    return m;
  endfunction : fmask

  task automatic set_prio(input int s, input logic [2:0] v);
    int i;
    i = SRC_REG[s];
    shadow[i] = (shadow[i] & ~(32'h7 << SRC_POS[s])) | (32'(v) << SRC_POS[s]);
    wr(pa(i), shadow[i]);
  endtask : set_prio

  // Outputs are registered: one edge after inputs, one more to settle
  task automatic irq_chk(input logic p, input logic [3:0] l, input logic [6:0] v);
    repeat (2) @(posedge pclk);
    if (p) chk(32'({irq_pending, irq_level, irq_vector}), 32'({p, l, v}));
    else chk(32'(irq_pending), 32'h0);
  endtask : irq_chk

  task automatic ack_once(input logic [3:0] d);
    int n;
    n = 0;
    dly <= d;
    arm <= 1'b1;
    @(posedge pclk);
    while (cpu_ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      miscompares++;
      close_out();
    end
    arm <= 1'b0;
    @(posedge pclk);
  endtask : ack_once

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = 4'hF; src_req = '0; trap_req = '0;
    cpu_level = '0; arm = 1'b0; dly = 4'h0; miscompares = 0; checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_PREG; i++) begin
      shadow[i] = fmask(i, 3'h4);
      rd_chk(pa(i), shadow[i], 1'b0);
      wr(pa(i), 32'hFFFFFFFF);
      rd_chk(pa(i), fmask(i, 3'h7), 1'b0);
      wr(pa(i), 32'h0);
      rd_chk(pa(i), 32'h0, 1'b0);
      wr(pa(i), shadow[i]);
    end
    rd_chk(OFS_STATUS, 32'h0, 1'b0);
    wr(OFS_STATUS, 32'hFFFFFFFF);
    rd_chk(OFS_STATUS, 32'h0, 1'b0);
    rd_chk(12'h044, 32'h0, 1'b1);
    rd_chk(OFS_EVT_MASK, 32'h0, 1'b0);
    wr(OFS_ENABLE, 32'h00FFFFFF);
    rd_chk(OFS_ENABLE, 32'h00FFFFFF, 1'b0);
    src_req <= 24'h000001;
    for (int c = 1; c < 8; c++) begin
      set_prio(0, 3'(c));
      cpu_level <= 4'(c - 1);
      irq_chk(1'b1, 4'(c), 7'h08);
      cpu_level <= 4'(c);
      irq_chk(1'b0, 4'h0, 7'h00);
    end
    cpu_level <= 4'h0;
    set_prio(0, 3'h6);
    set_prio(3, 3'h7);
    set_prio(5, 3'h7);
    src_req <= 24'h000029;
    irq_chk(1'b1, 4'h7, 7'h0B);
    ack_once(4'h3);
    rd_chk(OFS_STATUS, 32'h0000070B, 1'b0);
    src_req <= 24'h000001;
    irq_chk(1'b1, 4'h6, 7'h08);
    rd_chk(OFS_STATUS, 32'h0000070B, 1'b0);
    ack_once(4'h0);
    rd_chk(OFS_STATUS, 32'h00000608, 1'b0);
    set_prio(3, 3'h0);
    src_req <= 24'h000008;
    irq_chk(1'b0, 4'h0, 7'h00);
    set_prio(3, 3'h4);
    wr(OFS_ENABLE, 32'h00FFFFF7);
    irq_chk(1'b0, 4'h0, 7'h00);
    wr(OFS_ENABLE, 32'h00FFFFFF);
    irq_chk(1'b1, 4'h4, 7'h0B);
    cpu_level <= 4'hF;
    irq_chk(1'b0, 4'h0, 7'h00);
    trap_req <= 8'h04;
    irq_chk(1'b1, 4'hA, 7'h02);
    trap_req <= 8'h84;
    irq_chk(1'b1, 4'hF, 7'h07);
    ack_once(4'h1);
    trap_req <= 8'h00;
    src_req  <= 24'h000000;
    rd_chk(OFS_STATUS, 32'h00000F07, 1'b0);
    rd_chk(OFS_EVT_STS, 32'h7, 1'b0);
    chk(32'(evt_irq), 32'h0);
    wr(OFS_EVT_MASK, 32'h2);
    irq_chk(1'b0, 4'h0, 7'h00);
    chk(32'(evt_irq), 32'h1);
    wr(OFS_EVT_STS, 32'h2);
    rd_chk(OFS_EVT_STS, 32'h5, 1'b0);
    chk(32'(evt_irq), 32'h0);
    // Reset again mid-run: fields must come back to level 4
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(pa(0), fmask(0, 3'h4), 1'b0);
    rd_chk(OFS_STATUS, 32'h0, 1'b0);
    close_out();
  end
endmodule : tb
